// ### tscw_pkg.sv
// Package for the tuner serial control word bank
`default_nettype none
package tscw_pkg;
    // Frame lengths
    localparam int TSCW_LEN_BYTE = 8;
    localparam int TSCW_LEN_WORD = 16;
    localparam logic [4:0] TSCW_CNT_BYTE = 5'h08;
    localparam logic [4:0] TSCW_CNT_WORD = 5'h10;
    localparam logic [4:0] TSCW_CNT_MAX = 5'h1F;
    // Address codes
    localparam logic [1:0] TSCW_ADDR_00 = 2'h0;
    localparam logic [1:0] TSCW_ADDR_01 = 2'h1;
    localparam logic [1:0] TSCW_ADDR_10 = 2'h2;
    localparam logic [1:0] TSCW_ADDR_11 = 2'h3;
    // FM threshold sits three code steps above the AM scale
    localparam logic [4:0] TSCW_FM_RF_OFFSET = 5'h03;
    // Reset value of the shift bit: no shift
    localparam logic TSCW_SHIFT_RST = 1'h1;
    // Stored control groups
    typedef struct packed {
        logic [5:0] sel_thr;     // bits 5..0
        logic [5:0] if_osc;      // bits 11..6
        logic [5:0] band_rf;     // bits 17..12
        logic [5:0] pump;        // bits 23..18
        logic [6:0] first_alignment_converter_offset; // bits 30..24
        logic shift;             // bit 32
        logic [7:0] first_alignment_converter_gain;   // bits 45..38
        logic [2:0] sw;          // bits 48..46
    } tscw_bank_t;
    // Decoded controls to the analog section
    typedef struct packed {
        logic [2:0] if_agc_threshold;
        logic if_agc_disable;
        logic detector_test_select;
        logic feedback_divider_select;
        logic pll_on;
        logic [3:0] if_gain;
        logic vco_low_current;
        logic if_input_am;
        logic [3:0] rf_agc_code;
        logic [4:0] rf_agc_scaled;
        logic band_am;
        logic pump_delay_set_select;
        logic [1:0] first_pump_delay_field;
        logic [1:0] second_pump_delay_field;
        logic [1:0] active_pump_delay;
        logic [6:0] first_alignment_converter_offset;
        logic divider_shift;
        logic [7:0] first_alignment_converter_gain;
        logic second_pin_is_switch;
    } tscw_ctrl_t;
endpackage
`default_nettype wire

// ### tscw_bank.sv
// Three-wire serial control word bank with decoded tuner controls
//Contract
//- Bits 2..0 select IF-AGC threshold
//- Bit 16 high disables IF-AGC
//- Bit 3 enables detector test mode
//- Bit 5 picks feedback divider
//- Bits 9..6 set IF gain
//- Bit 11 selects AM IF input
//- Bit 10 selects low oscillator current
//- Bits 15..12 give RF-AGC threshold
//- FM threshold sits three steps above AM
//- Byte address 00 loads bits 5..0
//- Byte address 10 loads bits 17..12
//- Byte address 11 loads bits 23..18
//- Word 01 sets switch outputs, role
//- Bit 18 picks active pump delay
//- Bit 4 low disables synthesizer loop
//- Bit 17 high selects AM band
`default_nettype none
module tscw_bank
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Three-wire bus pins
    input wire logic bus_enable,
    input wire logic bus_clock,
    input wire logic bus_data,
    // Decoded controls
    output tscw_pkg::tscw_ctrl_t ctrl,
    // Open-drain switching outputs
    output logic first_switch_output_o,
    output logic first_switch_output_oe,
    output logic second_switch_or_gain_pin_o,
    output logic second_switch_or_gain_pin_oe,
    // Frame completion strobe
    output logic frame_done
);
    import tscw_pkg::*;

    // Three-stage pin synchronisers
    logic [2:0] en_sync_reg;
    logic [2:0] ck_sync_reg;
    logic [2:0] dt_sync_reg;
    logic en_state_reg;
    logic ck_state_reg;
    logic dat_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            en_sync_reg <= 3'h0;
            ck_sync_reg <= 3'h0;
            dt_sync_reg <= 3'h0;
        end
        else
        begin
            en_sync_reg <= {en_sync_reg[1:0], bus_enable};
            ck_sync_reg <= {ck_sync_reg[1:0], bus_clock};
            dt_sync_reg <= {dt_sync_reg[1:0], bus_data};
        end
    end

    // Level accepted only when stages two and three agree
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            en_state_reg <= 1'h0;
            ck_state_reg <= 1'h0;
            dat_reg <= 1'h0;
        end
        else
        begin
            if (en_sync_reg[2] == en_sync_reg[1])
                en_state_reg <= en_sync_reg[2];
            if (ck_sync_reg[2] == ck_sync_reg[1])
                ck_state_reg <= ck_sync_reg[2];
            if (dt_sync_reg[2] == dt_sync_reg[1])
                dat_reg <= dt_sync_reg[2];
        end
    end

    logic ck_next;
    logic en_next;
    logic ck_rise;
    logic en_fall;
    assign ck_next = (ck_sync_reg[2] == ck_sync_reg[1]) ? ck_sync_reg[2] : ck_state_reg;
    assign en_next = (en_sync_reg[2] == en_sync_reg[1]) ? en_sync_reg[2] : en_state_reg;
    assign ck_rise = ck_next && !ck_state_reg && en_state_reg;
    assign en_fall = en_state_reg && !en_next;

    // Shift register, MSB first; data is held stable while clock rises
    typedef enum {TSCW_IDLE, TSCW_SHIFT} tscw_state_t;
    tscw_state_t state_reg;
    logic [15:0] shift_reg;
    logic [4:0] count_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= TSCW_IDLE;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                TSCW_IDLE:
                begin
                    if (en_next && !en_state_reg)
                    begin
                        state_reg <= TSCW_SHIFT;
                        count_reg <= 5'h00;
                    end
                end
                TSCW_SHIFT:
                begin
                    if (en_fall)
                        state_reg <= TSCW_IDLE;
                    else if (ck_rise)
                    begin
                        shift_reg <= {shift_reg[14:0], dat_reg};
                        // Saturate so overlong frames are dropped, not wrapped
                        if (count_reg != TSCW_CNT_MAX)
                            count_reg <= count_reg + 5'h01;
                    end
                end
                default:
                    state_reg <= TSCW_IDLE;
            endcase
        end
    end

    // Frame decode on enable fall
    logic is_byte;
    logic is_word;
    logic [1:0] byte_addr;
    logic [1:0] word_addr;
    assign is_byte = en_fall && (state_reg == TSCW_SHIFT) && (count_reg == TSCW_CNT_BYTE);
    assign is_word = en_fall && (state_reg == TSCW_SHIFT) && (count_reg == TSCW_CNT_WORD);
    assign byte_addr = shift_reg[7:6];
    assign word_addr = shift_reg[7:6];

    tscw_bank_t bank_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bank_reg <= '0;
            bank_reg.shift <= TSCW_SHIFT_RST;
        end
        else if (is_byte)
        begin
            case (byte_addr)
                TSCW_ADDR_00: bank_reg.sel_thr <= shift_reg[5:0];
                TSCW_ADDR_01: bank_reg.if_osc <= shift_reg[5:0];
                TSCW_ADDR_10: bank_reg.band_rf <= shift_reg[5:0];
                TSCW_ADDR_11: bank_reg.pump <= shift_reg[5:0];
                default: bank_reg <= bank_reg;
            endcase
        end
        else if (is_word)
        begin
            // Words 10 and 11 carry the second converter, outside this bank
            case (word_addr)
                TSCW_ADDR_00:
                begin
                    bank_reg.first_alignment_converter_offset <= shift_reg[14:8];
                    bank_reg.shift <= shift_reg[0];
                end
                TSCW_ADDR_01:
                begin
                    bank_reg.first_alignment_converter_gain <= shift_reg[15:8];
                    bank_reg.sw <= shift_reg[2:0];
                end
                default: bank_reg <= bank_reg;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            frame_done <= 1'h0;
        else
            frame_done <= is_byte || is_word;
    end

    // Decoded controls, registered
    always_ff @(posedge clk)
    begin
        if (reset)
            ctrl <= '0;
        else
        begin
            ctrl.if_agc_threshold <= bank_reg.sel_thr[2:0];
            // Test mode; host keeps it zero
            ctrl.detector_test_select <= bank_reg.sel_thr[3];
            ctrl.pll_on <= bank_reg.sel_thr[4];
            ctrl.feedback_divider_select <= bank_reg.sel_thr[5];
            ctrl.if_gain <= bank_reg.if_osc[3:0];
            ctrl.vco_low_current <= bank_reg.if_osc[4];
            ctrl.if_input_am <= bank_reg.if_osc[5];
            ctrl.rf_agc_code <= bank_reg.band_rf[3:0];
            // Threshold offset from AM base, FM adds three steps
            ctrl.rf_agc_scaled <= {1'h0, bank_reg.band_rf[3:0]}
                + (bank_reg.band_rf[5] ? 5'h00 : TSCW_FM_RF_OFFSET);
            ctrl.if_agc_disable <= bank_reg.band_rf[4];
            ctrl.band_am <= bank_reg.band_rf[5];
            ctrl.pump_delay_set_select <= bank_reg.pump[0];
            ctrl.first_pump_delay_field <= bank_reg.pump[3:2];
            ctrl.second_pump_delay_field <= bank_reg.pump[5:4];
            ctrl.active_pump_delay <= bank_reg.pump[0] ? bank_reg.pump[5:4] : bank_reg.pump[3:2];
            ctrl.first_alignment_converter_offset <= bank_reg.first_alignment_converter_offset;
            ctrl.divider_shift <= bank_reg.shift;
            ctrl.first_alignment_converter_gain <= bank_reg.first_alignment_converter_gain;
            ctrl.second_pin_is_switch <= bank_reg.sw[2];
        end
    end

    // Open-drain pins pull low when bit set
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            first_switch_output_o <= 1'h0;
            first_switch_output_oe <= 1'h0;
            second_switch_or_gain_pin_o <= 1'h0;
            second_switch_or_gain_pin_oe <= 1'h0;
        end
        else
        begin
            first_switch_output_o <= 1'h0;
            first_switch_output_oe <= bank_reg.sw[0];
            second_switch_or_gain_pin_o <= 1'h0;
            // In gain mode the analog stage owns the pin
            second_switch_or_gain_pin_oe <= bank_reg.sw[2] && bank_reg.sw[1];
        end
    end

    // Byte groups reach ctrl two cycles after decode
    chk_byte_sel_thr: assert property (@(posedge clk) disable iff (reset)
        (is_byte && byte_addr == TSCW_ADDR_00) |=> ##1
        (ctrl.if_agc_threshold == $past(shift_reg[2:0], 2)))
        else $error("byte 00 not routed to threshold");
    chk_band_rf: assert property (@(posedge clk) disable iff (reset)
        (is_byte && byte_addr == TSCW_ADDR_10) |=> ##1
        (ctrl.band_am == $past(shift_reg[5], 2) && ctrl.if_agc_disable == $past(shift_reg[4], 2)))
        else $error("byte 10 not routed to band");
    chk_pump_byte: assert property (@(posedge clk) disable iff (reset)
        (is_byte && byte_addr == TSCW_ADDR_11) |=> ##1
        (ctrl.pump_delay_set_select == $past(shift_reg[0], 2)))
        else $error("byte 11 not routed to pump delay");
    // Fields register together; skip the edge right after reset
    chk_rf_scale: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> (ctrl.rf_agc_scaled == {1'h0, ctrl.rf_agc_code}
        + (ctrl.band_am ? 5'h00 : TSCW_FM_RF_OFFSET)))
        else $error("RF threshold offset wrong");
    chk_frame_pulse: assert property (@(posedge clk) disable iff (reset)
        frame_done |=> !frame_done)
        else $error("frame strobe longer than one cycle");
    chk_delay_select: assert property (@(posedge clk) disable iff (reset)
        ##1 (ctrl.active_pump_delay == (ctrl.pump_delay_set_select
        ? ctrl.second_pump_delay_field : ctrl.first_pump_delay_field)))
        else $error("active pump delay mismatch");
    chk_word_gain: assert property (@(posedge clk) disable iff (reset)
        (is_word && word_addr == TSCW_ADDR_01) |=> ##1 (ctrl.first_alignment_converter_gain == $past(shift_reg[15:8], 2)))
        else $error("gain word not stored");
    chk_word_shift: assert property (@(posedge clk) disable iff (reset)
        (is_word && word_addr == TSCW_ADDR_00) |=> ##1 (ctrl.divider_shift == $past(shift_reg[0], 2)))
        else $error("shift bit not stored");
    chk_switch_pin: assert property (@(posedge clk) disable iff (reset)
        (is_word && word_addr == TSCW_ADDR_01) |=> ##1
        (first_switch_output_oe == $past(shift_reg[0], 2)))
        else $error("first switch output wrong");
    chk_other_keep: assert property (@(posedge clk) disable iff (reset)
        (is_byte && byte_addr != TSCW_ADDR_00) |=> $stable(bank_reg.sel_thr))
        else $error("unaddressed group changed");
endmodule
`default_nettype wire

// ### tscw_host_model.sv
// Host model driving the three-wire control bus
`default_nettype none
module tscw_host_model
(
    // System clock for frame alignment
    input wire logic clk,
    // Three-wire bus
    output logic bus_enable,
    output logic bus_clock,
    output logic bus_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        bus_enable = 1'h0;
        bus_clock = 1'h0;
        bus_data = 1'h0;
    end
    // Sends the low n bits, MSB first; bus clock idles low between frames
    task automatic send(input logic [15:0] w, input int n);
        @(posedge clk);
        #1 bus_enable = 1'h1;
        for (int i = n - 1; i >= 0; i--)
        begin
            bus_data = w[i];
            #62.5 bus_clock = 1'h1;
            #62.5 bus_clock = 1'h0;
        end
        #62.5 bus_enable = 1'h0;
        // Released data line flips so a stale level is never mistaken for data
        bus_data = ~bus_data;
        #500;
    endtask
endmodule
`default_nettype wire

// ### tb_tscw_bank.sv
// Self-checking bench for the serial control word bank
`default_nettype none
module tb_tscw_bank;
    import tscw_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic bus_enable;
    logic bus_clock;
    logic bus_data;
    tscw_ctrl_t ctrl;
    logic sw1_o, sw1_oe, sw2_o, sw2_oe, frame_done;
    int num_errors = 0;
    int n_checks = 0;
    int n_done = 0;
    logic [7:0] bytes [8] = '{8'h37, 8'h7F, 8'h49, 8'h9E, 8'hAF, 8'hE5, 8'hD8, 8'h00};
    logic [15:0] words [3] = '{16'hA547, 16'hA544, 16'hA543};
    logic [2:0] pins [3] = '{3'h7, 3'h4, 3'h1};
    logic [5:0] d;
    always #5 clk = ~clk;
    always @(posedge clk) if (frame_done === 1'h1) n_done++;
    tscw_bank tscw_bank_inst (.clk(clk), .reset(reset), .bus_enable(bus_enable),
        .bus_clock(bus_clock), .bus_data(bus_data), .ctrl(ctrl),
        .first_switch_output_o(sw1_o), .first_switch_output_oe(sw1_oe),
        .second_switch_or_gain_pin_o(sw2_o), .second_switch_or_gain_pin_oe(sw2_oe),
        .frame_done(frame_done));
    tscw_host_model tscw_host_model_inst (.clk(clk), .bus_enable(bus_enable),
        .bus_clock(bus_clock), .bus_data(bus_data));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 reset = 1'h0;
        repeat (3) @(posedge clk);
        check("shift_rst", ctrl.divider_shift, 1'h1);
        check("sw1_oe_rst", sw1_oe, 1'h0);
        // Mandatory-zero positions are kept clear in every frame below
        for (int i = 0; i < 8; i++)
        begin
            tscw_host_model_inst.send({8'h00, bytes[i]}, 8);
            d = bytes[i][5:0];
            case (bytes[i][7:6])
                2'h0: check("grp00", {ctrl.feedback_divider_select, ctrl.pll_on,
                    ctrl.detector_test_select, ctrl.if_agc_threshold}, d);
                2'h1: check("grp01", {ctrl.if_input_am, ctrl.vco_low_current,
                    ctrl.if_gain}, d);
                2'h2:
                begin
                    check("grp10", {ctrl.band_am, ctrl.if_agc_disable,
                        ctrl.rf_agc_code}, d);
                    check("rf_scaled", ctrl.rf_agc_scaled,
                        d[5] ? {1'h0, d[3:0]} : d[3:0] + 5'h03);
                end
                default:
                begin
                    check("grp11", {ctrl.second_pump_delay_field,
                        ctrl.first_pump_delay_field, ctrl.pump_delay_set_select},
                        {d[5:2], d[0]});
                    check("pump_act", ctrl.active_pump_delay, d[0] ? d[5:4] : d[3:2]);
                end
            endcase
        end
        check("grp10_kept", {ctrl.band_am, ctrl.rf_agc_code}, 5'h1F);
        for (int i = 0; i < 3; i++)
        begin
            tscw_host_model_inst.send(words[i], 16);
            check("gain1", ctrl.first_alignment_converter_gain, 8'hA5);
            check("pins", {ctrl.second_pin_is_switch, sw2_oe, sw1_oe}, pins[i]);
            check("pin_lvl", {sw2_o, sw1_o}, 2'h0);
        end
        tscw_host_model_inst.send(16'h5A00, 16);
        check("offset1", ctrl.first_alignment_converter_offset, 7'h5A);
        check("shift", ctrl.divider_shift, 1'h0);
        check("n_done", 16'(n_done), 16'h000C);
        // Wrong length is dropped without a strobe
        tscw_host_model_inst.send(16'h037F, 12);
        check("n_drop", 16'(n_done), 16'h000C);
        // A word for the second converter ends cleanly but stores nothing here
        tscw_host_model_inst.send(16'h0080, 16);
        check("n_word10", 16'(n_done), 16'h000D);
        check("offset_kept", ctrl.first_alignment_converter_offset, 7'h5A);
        check("gain1_kept", ctrl.first_alignment_converter_gain, 8'hA5);
        check("gain_kept", ctrl.if_gain, 4'h9);
        check("rf_kept", {ctrl.band_am, ctrl.rf_agc_code}, 5'h1F);
        complete_run();
    end
endmodule
`default_nettype wire
